// ---- rtl/sfbce_pkg.sv ----
// Purpose: shared constants and types of the buffered page command engine
// Assumes: 100 MHz system clock, page of 264 bytes, two page buffers
// Notes:   opcodes, header layout, status layout, reset values and times
package sfbce_pkg;

  // ==========================================================================
  // geometry
  localparam int PAGE_BYTES  = 264;
  localparam int NUM_PAGES   = 1024;
  localparam int PROT_PAGES  = 256;
  localparam int PAGE_W      = 10;
  localparam int OFF_W       = 9;
  localparam int ARR_AW      = 19;
  localparam logic [8:0] LAST_BYTE = 9'h107;

  // ==========================================================================
  // serial frame layout: opcode, 5 reserved, 10 page, 9 offset bits
  localparam logic [5:0] OPC_BITS   = 6'h08;
  localparam logic [5:0] HDR_BITS   = 6'h20;
  localparam logic [5:0] DATA_END   = 6'h28;
  localparam int         HDR_OP_LSB = 24;
  localparam int         PAGE_LSB   = 9;
  localparam int         OFF_LSB    = 0;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_PTB_B1  = 8'h82;
  localparam logic [7:0] OP_PTB_B2  = 8'h85;
  localparam logic [7:0] OP_PEP_B1  = 8'h83;
  localparam logic [7:0] OP_PEP_B2  = 8'h86;
  localparam logic [7:0] OP_XFR_B1  = 8'h53;
  localparam logic [7:0] OP_XFR_B2  = 8'h55;
  localparam logic [7:0] OP_CMP_B1  = 8'h60;
  localparam logic [7:0] OP_CMP_B2  = 8'h61;
  localparam logic [7:0] OP_RWR_B1  = 8'h58;
  localparam logic [7:0] OP_RWR_B2  = 8'h59;
  localparam logic [7:0] OP_BWR_B1  = 8'h84;
  localparam logic [7:0] OP_BWR_B2  = 8'h87;
  localparam logic [7:0] OP_STAT_A  = 8'h57;
  localparam logic [7:0] OP_STAT_B  = 8'hD7;

  // ==========================================================================
  // status byte, reset values, fill value
  localparam int         ST_RDY_BIT   = 7;
  localparam int         ST_COMP_BIT  = 6;
  localparam logic [3:0] DENSITY_CODE = 4'h0;  // arbitrary value
  localparam logic       MODE3_RST    = 1'b1;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;

  // ==========================================================================
  // timing: erase_program_time and page_copy_time in ns
  localparam int CLK_PERIOD_NS        = 10;
  localparam int ERASE_PROGRAM_TIME_NS = 20000;
  localparam int PAGE_COPY_TIME_NS     = 10000;
  localparam int TMR_W                 = 16;

  // ==========================================================================
  // sequencer states, gray along copy-erase-program-hold
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_COPY  = 3'b001,
    ST_ERASE = 3'b011,
    ST_PROG  = 3'b010,
    ST_HOLD  = 3'b110,
    ST_CMP   = 3'b100
  } sfbce_state_t;

endpackage

// ---- rtl/sfbce_engine.sv ----
// Purpose: buffered page command engine of a serial page flash with two buffers
// Assumes: sck_i is a clock of its own; cs_n_i, wp_n_i come from pins
// Notes:   array and buffers modelled as arrays; srst_i is the reset pin
`timescale 1ns/1ps

module sfbce_engine
  import sfbce_pkg::*;
#(
  parameter int PAGES       = NUM_PAGES,
  parameter int EP_TIME_NS  = ERASE_PROGRAM_TIME_NS,
  parameter int XFR_TIME_NS = PAGE_COPY_TIME_NS
) (
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  input  wire logic wp_n_i,
  output logic      so_o,
  output logic      so_oe_n_o,
  output logic      busy_o,
  output logic      busy_oe_n_o,
  output logic      spi_mode3_o,
  output logic      ready_o,
  output logic      comp_o
);

  // least cycle counts, longest times round down
  localparam int EP_CYC  = EP_TIME_NS / CLK_PERIOD_NS;
  localparam int XFR_CYC = XFR_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // state types
  typedef struct packed {
    logic [5:0]  cnt;
    logic [31:0] sh;
    logic        stat;
  } sfbce_frm_t;
  typedef struct packed {
    logic [31:0] hdr;
    logic [7:0]  dat;
    logic        hdr_t;
    logic        byte_t;
  } sfbce_lnk_t;
  typedef struct packed {
    logic [2:0] idx;
    logic       so;
    logic       oe_n;
    logic [1:0] rdy_s;
    logic [1:0] cmp_s;
  } sfbce_out_t;
  typedef struct packed {
    sfbce_state_t     state;
    logic [8:0]       idx;
    logic [TMR_W-1:0] tmr;
    logic             chain;
    logic             rb;
    logic [PAGE_W-1:0] rpage;
    logic             hv;
    logic [7:0]       hop;
    logic [PAGE_W-1:0] hpage;
    logic [OFF_W-1:0] wptr;
    logic             comp;
    logic             mism;
    logic             mode3;
    logic [3:0]       cs_s;
    logic [2:0]       ht_s;
    logic [2:0]       bt_s;
    logic [2:0]       sck_s;
    logic [1:0]       wp_s;
    logic             busy_oe_n;
    logic             rdy;
  } sfbce_sys_t;
  sfbce_frm_t frm_r, frm_nxt;
  sfbce_lnk_t lnk_r, lnk_nxt;
  sfbce_out_t out_r, out_nxt;
  sfbce_sys_t s_r, s_nxt;
  logic [7:0]        flash_mem [PAGES*PAGE_BYTES];
  logic [7:0]        bufm      [2][PAGE_BYTES];
  logic [5:0]        bit_cnt;
  logic [31:0]       bits_in;
  logic [7:0]        stat_byte;
  logic [ARR_AW-1:0] arr_a;
  logic [7:0]        arr_q;
  logic [7:0]        run_q;
  logic              cs_rise;
  logic              cs_fall;
  logic              hdr_ev;
  logic              byte_ev;
  logic              busy;
  logic              hb;
  logic              prot;
  logic              bw_en;
  logic              cw_en;
  logic              aw_en;
  logic [7:0]        aw_d;
  logic              cmp_ne;

  // ==========================================================================
  // opcode classes
  function automatic logic op_b2(input logic [7:0] op);
    return op inside {OP_PTB_B2, OP_PEP_B2, OP_XFR_B2, OP_CMP_B2, OP_RWR_B2, OP_BWR_B2};
  endfunction
  function automatic logic op_prog(input logic [7:0] op);
    return op inside {OP_PTB_B1, OP_PTB_B2, OP_PEP_B1, OP_PEP_B2};
  endfunction
  function automatic logic op_wdata(input logic [7:0] op);
    return op inside {OP_PTB_B1, OP_PTB_B2, OP_BWR_B1, OP_BWR_B2};
  endfunction

  // ==========================================================================
  // link side: shift on rising sck, frame state cleared while cs high
  always_comb begin
    bit_cnt = frm_r.cnt + 6'h01;
    bits_in = {frm_r.sh[30:0], si_i};
    frm_nxt = frm_r;
    lnk_nxt = lnk_r;
    frm_nxt.sh  = bits_in;
    frm_nxt.cnt = (bit_cnt == DATA_END) ? HDR_BITS : bit_cnt;
    // status read opcode turns the output on
    if (bit_cnt == OPC_BITS && (bits_in[7:0] == OP_STAT_A || bits_in[7:0] == OP_STAT_B)) begin
      frm_nxt.stat = 1'b1;
    end
    // full header only; a short frame never toggles
    if (bit_cnt == HDR_BITS && !frm_r.stat) begin
      lnk_nxt.hdr   = bits_in;
      lnk_nxt.hdr_t = ~lnk_r.hdr_t;
    end
    // each whole data byte after the header
    if (bit_cnt == DATA_END) begin
      lnk_nxt.dat    = bits_in[7:0];
      lnk_nxt.byte_t = ~lnk_r.byte_t;
    end
  end
  // frame registers: cs high forces them clear, si ignored
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      frm_r <= '0;
    end else begin
      frm_r <= frm_nxt;
    end
  end
  // held header and data with their event toggles
  always_ff @(posedge sck_i or posedge srst_i) begin
    if (srst_i) begin
      lnk_r <= '0;
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // ==========================================================================
  // output side: status byte shifted on falling sck, repeats while selected
  assign stat_byte = {out_r.rdy_s[1], out_r.cmp_s[1], DENSITY_CODE, 2'b00};
  always_comb begin
    out_nxt = out_r;
    out_nxt.rdy_s = {out_r.rdy_s[0], s_r.rdy};
    out_nxt.cmp_s = {out_r.cmp_s[0], s_r.comp};
    if (frm_r.stat) begin
      out_nxt.oe_n = 1'b0;
      out_nxt.so   = stat_byte[out_r.idx];
      out_nxt.idx  = out_r.idx - 3'h1;
    end
  end

  // released the moment cs goes high; srst_i does not touch it
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_r <= '{idx: 3'h7, so: 1'b0, oe_n: 1'b1, rdy_s: 2'b00, cmp_s: 2'b00};
    end else begin
      out_r <= out_nxt;
    end
  end

  // ==========================================================================
  // system side: events from synchronised pins and toggles
  // cs rise waits one stage more so the last byte toggle lands first
  assign cs_rise = s_r.cs_s[2] & ~s_r.cs_s[3];
  assign cs_fall = ~s_r.cs_s[1] & s_r.cs_s[2];
  assign hdr_ev  = s_r.ht_s[1] ^ s_r.ht_s[2];
  assign byte_ev = s_r.bt_s[1] ^ s_r.bt_s[2];
  assign busy    = (s_r.state != ST_IDLE);
  assign hb      = op_b2(s_r.hop);
  assign prot    = ~s_r.wp_s[1] && (32'(s_r.hpage) < PROT_PAGES);

  // array and buffer ports
  assign arr_a  = ARR_AW'(32'(s_r.rpage) * PAGE_BYTES) + ARR_AW'(s_r.idx);
  assign arr_q  = flash_mem[arr_a];
  assign run_q  = bufm[s_r.rb][s_r.idx];
  assign cmp_ne = (s_r.state == ST_CMP) && (arr_q != run_q);
  assign cw_en  = (s_r.state == ST_COPY);
  assign aw_en  = (s_r.state == ST_ERASE) || (s_r.state == ST_PROG);
  assign aw_d   = (s_r.state == ST_ERASE) ? ERASED_BYTE : run_q;
  // buffer in use is locked while busy, the other one stays open
  assign bw_en  = byte_ev && s_r.hv && op_wdata(s_r.hop)
                  && !(busy && (s_r.rb == hb));

  always_comb begin
    s_nxt = s_r;
    s_nxt.cs_s  = {s_r.cs_s[2:0], cs_n_i};
    s_nxt.ht_s  = {s_r.ht_s[1:0], lnk_r.hdr_t};
    s_nxt.bt_s  = {s_r.bt_s[1:0], lnk_r.byte_t};
    s_nxt.sck_s = {s_r.sck_s[1:0], sck_i};
    s_nxt.wp_s  = {s_r.wp_s[0], wp_n_i};
    if (s_r.tmr != '0) begin
      s_nxt.tmr = s_r.tmr - TMR_W'(1);
    end
    // frame start: drop old header; clock level taken with cs_s[2], still
    // deselected, so a first clock edge soon after select fall cannot leak in
    if (cs_fall) begin
      s_nxt.hv    = 1'b0;
      s_nxt.mode3 = s_r.sck_s[2];
    end
    if (hdr_ev) begin
      s_nxt.hv    = 1'b1;
      s_nxt.hop   = lnk_r.hdr[HDR_OP_LSB +: 8];
      s_nxt.hpage = lnk_r.hdr[PAGE_LSB +: PAGE_W];
      s_nxt.wptr  = lnk_r.hdr[OFF_LSB +: OFF_W];
    end
    if (bw_en) begin
      s_nxt.wptr = (s_r.wptr == LAST_BYTE) ? '0 : s_r.wptr + 9'h001;
    end
    // dispatch at frame end; host keeps array commands apart
    if (cs_rise && s_r.hv) begin
      s_nxt.hv = 1'b0;
      if (!busy) begin
        s_nxt.rpage = s_r.hpage;
        s_nxt.rb    = hb;
        s_nxt.idx   = '0;
        s_nxt.chain = 1'b0;
        s_nxt.mism  = 1'b0;
        if (op_prog(s_r.hop) && !prot) begin
          s_nxt.state = ST_ERASE;
          s_nxt.tmr   = TMR_W'(EP_CYC);
        end else if (s_r.hop == OP_XFR_B1 || s_r.hop == OP_XFR_B2) begin
          s_nxt.state = ST_COPY;
          s_nxt.tmr   = TMR_W'(XFR_CYC);
        end else if (s_r.hop == OP_CMP_B1 || s_r.hop == OP_CMP_B2) begin
          s_nxt.state = ST_CMP;
          s_nxt.tmr   = TMR_W'(XFR_CYC);
        end else if ((s_r.hop == OP_RWR_B1 || s_r.hop == OP_RWR_B2) && !prot) begin
          s_nxt.state = ST_COPY;
          s_nxt.chain = 1'b1;
          s_nxt.tmr   = TMR_W'(EP_CYC);
        end
      end
    end
    // byte loop over the page, one byte per cycle
    if (s_r.state != ST_IDLE && s_r.state != ST_HOLD) begin
      s_nxt.idx = (s_r.idx == LAST_BYTE) ? '0 : s_r.idx + 9'h001;
    end
    unique case (s_r.state)
      ST_IDLE: begin
      end
      ST_COPY: begin
        if (s_r.idx == LAST_BYTE) begin
          s_nxt.state = s_r.chain ? ST_ERASE : ST_HOLD;
        end
      end
      ST_ERASE: begin
        if (s_r.idx == LAST_BYTE) begin
          s_nxt.state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (s_r.idx == LAST_BYTE) begin
          s_nxt.state = ST_HOLD;
        end
      end
      ST_CMP: begin
        s_nxt.mism = s_r.mism | cmp_ne;
        if (s_r.idx == LAST_BYTE) begin
          s_nxt.comp  = s_r.mism | cmp_ne;
          s_nxt.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // stays busy for the rest of the self-timed window
        if (s_r.tmr == '0) begin
          s_nxt.state = ST_IDLE;
        end
      end
    endcase
    s_nxt.busy_oe_n = (s_nxt.state == ST_IDLE);
    s_nxt.rdy       = (s_nxt.state == ST_IDLE);
    // reset pin aborts the sequencer and clears system-side state; mode3, cs_s, wp_s, busy_oe_n and rdy go high
    if (srst_i) begin
      s_nxt = '0;
      s_nxt.state     = ST_IDLE;
      s_nxt.mode3     = MODE3_RST;
      s_nxt.cs_s      = 4'hF;
      s_nxt.wp_s      = 2'h3;
      s_nxt.busy_oe_n = 1'b1;
      s_nxt.rdy       = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    s_r <= s_nxt;
  end
  // array and buffers; no reset, contents survive
  always_ff @(posedge clk_sys_i) begin
    if (aw_en && !srst_i) begin
      flash_mem[arr_a] <= aw_d;
    end
    if (cw_en && !srst_i) begin
      bufm[s_r.rb][s_r.idx] <= arr_q;
    end
    if (bw_en && !srst_i) begin
      bufm[hb][s_r.wptr] <= lnk_r.dat;
    end
  end

  // ==========================================================================
  // outputs
  assign so_o        = out_r.so;
  assign so_oe_n_o   = out_r.oe_n;
  assign busy_o      = 1'b0;
  assign busy_oe_n_o = s_r.busy_oe_n;
  assign spi_mode3_o = s_r.mode3;
  assign ready_o     = s_r.rdy;
  assign comp_o      = s_r.comp;

  // ==========================================================================
  // checks
  property p_erase_len;
    @(posedge clk_sys_i) disable iff (srst_i)
    (s_r.state == ST_ERASE && $past(s_r.state) == ST_IDLE) |-> ##264 (s_r.state == ST_PROG);
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase pass length wrong");
  property p_copy_len;
    @(posedge clk_sys_i) disable iff (srst_i)
    $rose(s_r.state == ST_COPY) |-> ##264 (s_r.state == ST_HOLD || s_r.state == ST_ERASE);
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy pass length wrong");
  property p_busy_pin;
    @(posedge clk_sys_i) disable iff (srst_i)
    (s_r.state != ST_IDLE) |-> (!busy_oe_n_o && !ready_o);
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("busy not shown");
  property p_comp_upd;
    @(posedge clk_sys_i) disable iff (srst_i)
    (s_r.state == ST_CMP && s_r.idx == LAST_BYTE) |=> (comp_o == ($past(s_r.mism) || $past(cmp_ne)));
  endproperty
  a_comp_upd: assert property (p_comp_upd) else $error("compare bit wrong");
  property p_prot;
    @(posedge clk_sys_i) disable iff (srst_i)
    (cs_rise && s_r.hv && prot && op_prog(s_r.hop) && !busy) |=> (s_r.state == ST_IDLE)[*2];
  endproperty
  a_prot: assert property (p_prot) else $error("protected page programmed");
  property p_short;
    @(posedge clk_sys_i) disable iff (srst_i)
    (cs_rise && !s_r.hv && !busy) |=> (s_r.state == ST_IDLE);
  endproperty
  a_short: assert property (p_short) else $error("short frame started work");
  property p_wrap;
    @(posedge clk_sys_i) disable iff (srst_i)
    (bw_en && s_r.wptr == LAST_BYTE) |=> (s_r.wptr == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("buffer pointer did not wrap");
  property p_mode;
    @(posedge clk_sys_i) disable iff (srst_i)
    cs_fall |=> (spi_mode3_o == $past(s_r.sck_s[2]));
  endproperty
  a_mode: assert property (p_mode) else $error("mode not taken at select fall");
  property p_reset;
    @(posedge clk_sys_i)
    $fell(srst_i) |-> (s_r.state == ST_IDLE && spi_mode3_o && ready_o);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule

// ---- tb/sfbce_host_model.sv ----
// Purpose: serial host model driving the engine's link pins
// Assumes: 6 ns serial clock, produced only inside frames
// Notes:   the bench calls the tasks; mode3_r picks the idle clock level
`timescale 1ns/1ps

module sfbce_host_model (
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i
);
  logic mode3_r;  // idle clock level between frames

  // clock stands still and select is high outside frames
  initial begin
    mode3_r = 1'b1;
    sck_o   = 1'b1;
    cs_n_o  = 1'b1;
    si_o    = 1'b0;
  end

  // ==========================================================================
  // bit level
  // si changes while the clock is low, so is read at the rising edge
  task automatic tx_bit(input logic b, output logic r);
    sck_o = 1'b0;
    si_o  = b;
    #3;
    sck_o = 1'b1;
    r     = so_i;
    #3;
  endtask

  // frame opens on select fall with the clock at its idle level
  task automatic open_frame();
    sck_o  = mode3_r;
    #3;
    cs_n_o = 1'b0;
    #6;
  endtask

  // close half a period after the last bit; released si shows inverse
  task automatic close_frame();
    #3;
    sck_o  = mode3_r;
    #3;
    cs_n_o = 1'b1;
    si_o   = ~si_o;
    #60;  // at least four system cycles between frames
  endtask

  // idle level is only moved while deselected
  task automatic set_mode(input logic m3);
    mode3_r = m3;
    sck_o   = m3;
    #20;
  endtask

  // ==========================================================================
  // frames
  // header MSB first: opcode, 5 reserved, page, offset; nh below 32 cuts it
  // data: d0 first, then d1 for every further byte, so one call can fill a buffer
  task automatic cmd(input logic [7:0] op, input logic [9:0] pg, input logic [8:0] off,
                     input int nh, input int nd, input logic [7:0] d0, input logic [7:0] d1);
    logic [31:0] h;
    logic [7:0]  d;
    logic        r;
    h = {op, 5'h00, pg, off};
    open_frame();
    for (int i = 31; i > 31 - nh; i--) begin
      tx_bit(h[i], r);
    end
    for (int j = 0; j < nd; j++) begin
      d = (j == 0) ? d0 : d1;
      for (int i = 7; i >= 0; i--) begin
        tx_bit(d[i], r);
      end
    end
    close_frame();
  endtask

  // status read: opcode out, then eight bits back
  task automatic stat(input logic [7:0] op, output logic [7:0] s);
    logic r;
    open_frame();
    for (int i = 7; i >= 0; i--) begin
      tx_bit(op[i], r);
    end
    for (int i = 7; i >= 0; i--) begin
      tx_bit(1'b0, s[i]);
    end
    close_frame();
  endtask
endmodule

// ---- tb/serial_flash_buffer_command_engine_tb.sv ----
// Purpose: self-checking bench of the buffered page command engine
// Assumes: shortened erase/program and copy times, 100 MHz system clock
// Notes: host waits for ready before any array command
`timescale 1ns/1ps

module serial_flash_buffer_command_engine_tb;
  import sfbce_pkg::*;
  logic       clk_sys_i;
  logic       srst_i;
  logic       wp_n_i;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       so;
  logic       so_oe_n;
  logic       busy;
  logic       busy_oe_n;
  logic       mode3;
  logic       rdy;
  logic       comp;
  logic [7:0] s;
  int         fail_count   = 0;
  int         total_checks = 0;
  int         cyc          = 0;
  int         n;
  int         busy_run     = 0;
  int         busy_len     = 0;

  // shortened self-timed windows and their lengths in system cycles
  localparam int EP_NS   = 8000;
  localparam int XFR_NS  = 3000;
  localparam int EP_CYC  = EP_NS / CLK_PERIOD_NS;
  localparam int XFR_CYC = XFR_NS / CLK_PERIOD_NS;

  sfbce_engine #(.EP_TIME_NS(EP_NS), .XFR_TIME_NS(XFR_NS)) dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .wp_n_i(wp_n_i), .so_o(so), .so_oe_n_o(so_oe_n), .busy_o(busy),
    .busy_oe_n_o(busy_oe_n), .spi_mode3_o(mode3), .ready_o(rdy), .comp_o(comp));

  sfbce_host_model h (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));

  // ==========================================================================
  // clock, hang guard, checks
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // length of the last busy stretch, taken from the pin enable
  always @(posedge clk_sys_i) begin
    if (busy_oe_n === 1'b0) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end

  // the whole run needs about 7700 cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // busy pin and ready must drop within a bounded number of cycles
  task automatic wait_busy();
    n = 0;
    while (busy_oe_n !== 1'b0 && n < 40) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk(busy_oe_n, 1'b0, "busy pin");
    chk(rdy, 1'b0, "ready low");
    chk(busy, 1'b0, "busy drive level");
  endtask

  // n ends up as the cycles waited for ready, at most 2500
  task automatic wait_ready();
    n = 0;
    while (rdy !== 1'b1 && n < 2500) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    // one more edge so the busy length monitor has latched
    @(posedge clk_sys_i);
    #1;
    chk(rdy, 1'b1, "ready back");
    chk(busy_oe_n, 1'b1, "busy released");
  endtask

  // busy pin must stay released for c cycles
  task automatic quiet(input int c);
    int bad;
    bad = 0;
    repeat (c) begin
      @(posedge clk_sys_i);
      #1;
      if (busy_oe_n !== 1'b1) bad++;
    end
    chk(bad[7:0], 8'h00, "unexpected busy");
  endtask

  task automatic cmp_exp(input logic [7:0] op, input logic e);
    h.cmd(op, 10'd300, 9'h000, 32, 0, 8'h00, 8'h00);
    wait_busy();
    wait_ready();
    chk(comp, e, "compare result");
    chk(busy_len >= XFR_CYC && busy_len <= XFR_CYC + 4, 1'b1, "compare length");
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_state();
    chk({rdy, busy_oe_n, mode3, comp, so_oe_n}, 8'h1D, "reset state");
  endtask

  // whole buffer filled first so that page compares see only known bytes
  task automatic t_program_compare();
    h.cmd(OP_BWR_B1, 10'd0, 9'h000, 32, PAGE_BYTES, 8'h3C, 8'hC3);
    h.cmd(OP_PTB_B1, 10'd300, LAST_BYTE, 32, 2, 8'h5A, 8'hA5);
    wait_busy();
    h.stat(OP_STAT_A, s);
    chk(s[7], 1'b0, "status busy");
    wait_ready();
    chk(busy_len >= EP_CYC && busy_len <= EP_CYC + 4, 1'b1, "program length");
    h.stat(OP_STAT_B, s);
    chk(s, {2'b10, DENSITY_CODE, 2'b00}, "status ready");
    cmp_exp(OP_CMP_B1, 1'b0);
    h.cmd(OP_BWR_B1, 10'd0, 9'h000, 32, 1, 8'hA4, 8'h00);
    cmp_exp(OP_CMP_B1, 1'b1);
    h.cmd(OP_BWR_B1, 10'd0, 9'h000, 32, 1, 8'hA5, 8'h00);
    cmp_exp(OP_CMP_B1, 1'b0);
  endtask

  task automatic t_transfer();
    h.cmd(OP_XFR_B2, 10'd300, 9'h000, 32, 0, 8'h00, 8'h00);
    wait_busy();
    wait_ready();
    chk(busy_len >= XFR_CYC && busy_len <= XFR_CYC + 4, 1'b1, "transfer length");
    cmp_exp(OP_CMP_B2, 1'b0);
  endtask

  task automatic t_other_buffer();
    h.cmd(OP_PTB_B1, 10'd300, 9'h000, 32, 0, 8'h00, 8'h00);
    wait_busy();
    h.cmd(OP_BWR_B2, 10'd0, 9'h000, 32, 1, 8'hA4, 8'h00);
    h.cmd(OP_BWR_B1, 10'd0, 9'h000, 32, 1, 8'h77, 8'h00);
    wait_ready();
    cmp_exp(OP_CMP_B2, 1'b1);
    cmp_exp(OP_CMP_B1, 1'b0);
  endtask

  // rewriting the page copies it into buffer 2, then erases and programs it back
  task automatic t_rewrite();
    h.cmd(OP_RWR_B2, 10'd300, 9'h000, 32, 0, 8'h00, 8'h00);
    wait_busy();
    wait_ready();
    chk(busy_len >= EP_CYC && busy_len <= EP_CYC + 4, 1'b1, "rewrite length");
    cmp_exp(OP_CMP_B2, 1'b0);
  endtask

  task automatic t_protect();
    @(posedge clk_sys_i);
    wp_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    h.cmd(OP_PTB_B1, 10'd5, 9'h000, 32, 1, 8'h11, 8'h00);
    quiet(40);
    h.cmd(OP_RWR_B1, 10'd255, 9'h000, 32, 0, 8'h00, 8'h00);
    quiet(40);
    h.cmd(OP_PTB_B1, 10'd256, 9'h000, 32, 0, 8'h00, 8'h00);
    wait_busy();
    wait_ready();
    @(posedge clk_sys_i);
    wp_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask

  task automatic t_short_frame();
    h.cmd(OP_PTB_B1, 10'd300, 9'h000, 16, 0, 8'h00, 8'h00);
    quiet(40);
    h.cmd(OP_XFR_B1, 10'd300, 9'h000, 31, 0, 8'h00, 8'h00);
    quiet(40);
  endtask

  task automatic t_mode();
    h.set_mode(1'b0);
    h.stat(OP_STAT_B, s);
    chk(mode3, 1'b0, "mode 0 picked");
    chk(s[7], 1'b1, "status in mode 0");
    h.set_mode(1'b1);
    h.stat(OP_STAT_A, s);
    chk(mode3, 1'b1, "mode 3 picked");
    chk(so_oe_n, 1'b1, "so released");
  endtask

  task automatic t_reset_mid();
    h.cmd(OP_PTB_B1, 10'd300, 9'h000, 32, 0, 8'h00, 8'h00);
    wait_busy();
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk({rdy, busy_oe_n, mode3, comp}, 8'h0E, "abort state");
    quiet(20);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    srst_i = 1'b1;
    wp_n_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    t_reset_state();
    t_program_compare();
    t_transfer();
    t_other_buffer();
    t_rewrite();
    t_protect();
    t_short_frame();
    t_mode();
    t_reset_mid();
    print_verdict();
  end
endmodule
